// [hw/lane_control_pkg.sv]
// Constants for the lane 4 and lane 5 control register bank
package lane_control_pkg;

	// Register bus
	localparam int              ADDR_W              = 8;
	localparam int              DATA_W              = 32;
	localparam int              STRB_W              = DATA_W / 8;

	// Lane slots held by this bank: slot 0 is lane 4, slot 1 is lane 5
	localparam int              SLOT_COUNT          = 2;
	localparam int              SLOT_W              = 2;

	// Byte offsets, one aligned word each
	localparam logic [7:0]      LANE4_CONTROL_OFFSET = 8'h14;
	localparam logic [7:0]      LANE5_CONTROL_OFFSET = 8'h18;

	// Field positions inside each lane control register
	localparam int              INVERT_BIT          = 0;
	localparam int              POWER_OFF_BIT       = 1;
	localparam int              RESERVE_BIT         = 2;
	localparam int              FIELD_W             = 3;

	// Reset values of the fields
	localparam logic            INVERT_RESET        = 1'b0;
	localparam logic            POWER_OFF_RESET     = 1'b0;
	localparam logic            RESERVE_RESET       = 1'b1;

	// Power-down vector
	localparam int              POWER_VEC_W         = 8;
	localparam int              LANE4_VEC_INDEX     = 4;
	localparam int              LANE5_VEC_INDEX     = 5;

	// Read value of unmapped space and of the upper bits
	localparam logic [31:0]     READ_ZERO           = 32'h0000_0000;

endpackage : lane_control_pkg

// [hw/lane_control_regs.sv]
// Lane 4 and lane 5 control registers with APB slave, power-down vector and polarity inversion
//
// Contract
// - Separate control registers for lane 4 and lane 5, each with three bits.
// - Bit 2 is a read-write reserve bit, reset to one.
// - Bit 1 is read-write power-down: zero normal, one powered down; resets zero.
// - Stored power-down bit drives its own element of the lane power-down vector.
// - Transport layer treats a powered-down lane as fallen back.
// - Bit 0 is read-write polarity control, reset zero; one inverts all received bits.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps

module lane_control_regs
	import lane_control_pkg::*;
#(
	parameter int RX_DATA_W = 32
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    clkEn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_W-1:0]       paddr,
	input  wire logic [DATA_W-1:0]       pwdata,
	input  wire logic [STRB_W-1:0]       pstrb,
	output logic      [DATA_W-1:0]       prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Lane power-down vector toward the transceiver reset logic
	output logic      [POWER_VEC_W-1:0]  lanePowerDown,
	// Received data, lane 4
	input  wire logic [RX_DATA_W-1:0]    rxData4,
	input  wire logic                    rxValid4,
	output logic      [RX_DATA_W-1:0]    rxDataOut4,
	output logic                         rxValidOut4,
	// Received data, lane 5
	input  wire logic [RX_DATA_W-1:0]    rxData5,
	input  wire logic                    rxValid5,
	output logic      [RX_DATA_W-1:0]    rxDataOut5,
	output logic                         rxValidOut5,
	// Transport layer view of the lanes
	output logic      [SLOT_COUNT-1:0]   laneFallback,
	output logic      [SLOT_W-1:0]       activeLaneCount
);

	// Stored fields, one element per lane slot
	logic [SLOT_COUNT-1:0]  laneReserveBit;
	logic [SLOT_COUNT-1:0]  lanePowerOffCtl;
	logic [SLOT_COUNT-1:0]  laneInvertCtl;

	// Bus decode
	logic                   setupPhase;
	logic                   accessPhase;
	logic [SLOT_COUNT-1:0]  slotHit;
	logic                   anyHit;
	logic                   writeLow;
	logic [DATA_W-1:0]      next_prdata;

	// Per-slot data path
	logic [RX_DATA_W-1:0]   rxDataIn   [SLOT_COUNT];
	logic                   rxValidIn  [SLOT_COUNT];
	logic [RX_DATA_W-1:0]   rxDataReg  [SLOT_COUNT];
	logic                   rxValidReg [SLOT_COUNT];

	assign rxDataIn[0]  = rxData4;
	assign rxDataIn[1]  = rxData5;
	assign rxValidIn[0] = rxValid4;
	assign rxValidIn[1] = rxValid5;

	// Phases of an APB transfer
	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;

	// Address decode, one register per lane
	always_comb begin
		slotHit    = '0;
		slotHit[0] = (paddr == LANE4_CONTROL_OFFSET[ADDR_W-1:0]);
		slotHit[1] = (paddr == LANE5_CONTROL_OFFSET[ADDR_W-1:0]);
	end

	assign anyHit = |slotHit;

	// All three fields live in byte lane 0
	assign writeLow = pstrb[0];

	// Read data assembled from the addressed lane
	always_comb begin
		next_prdata = READ_ZERO;
		for (int s = 0; s < SLOT_COUNT; s++) begin
			if (slotHit[s]) begin
				next_prdata[RESERVE_BIT]   = laneReserveBit[s];
				next_prdata[POWER_OFF_BIT] = lanePowerOffCtl[s];
				next_prdata[INVERT_BIT]    = laneInvertCtl[s];
			end
		end
	end

	// Ready only while the clock enable lets the access complete
	assign pready = accessPhase && clkEn;

	// Read data captured in the setup cycle so it comes from flip-flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prdata <= READ_ZERO;
		end else if (clkEn && setupPhase) begin
			prdata <= pwrite ? READ_ZERO : next_prdata;
		end
	end

	// Unmapped addresses answer with an error, nothing is stored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else if (clkEn && setupPhase) begin
			pslverr <= !anyHit;
		end
	end

	// Writes land only at the completing edge; upper bits are never stored
	generate
		for (genvar s = 0; s < SLOT_COUNT; s++) begin : gSlot
			logic takeWrite;

			assign takeWrite = accessPhase && pwrite && slotHit[s] && writeLow;

			// One slot per lane keeps both lanes identical by construction
			lane_slot #(
				.RX_DATA_W   (RX_DATA_W)
			) slotInst (
				.clk_sys     (clk_sys),
				.rst         (rst),
				.clkEn       (clkEn),
				.takeWrite   (takeWrite),
				.wrData      (pwdata),
				.rxDataIn    (rxDataIn[s]),
				.rxValidIn   (rxValidIn[s]),
				.reserveBit  (laneReserveBit[s]),
				.powerOffCtl (lanePowerOffCtl[s]),
				.invertCtl   (laneInvertCtl[s]),
				.rxDataOut   (rxDataReg[s]),
				.rxValidOut  (rxValidReg[s])
			);
		end
	endgenerate

	assign rxDataOut4  = rxDataReg[0];
	assign rxDataOut5  = rxDataReg[1];
	assign rxValidOut4 = rxValidReg[0];
	assign rxValidOut5 = rxValidReg[1];

	// Only lanes 4 and 5 belong to this bank; other elements stay low
	always_comb begin
		lanePowerDown                  = '0;
		lanePowerDown[LANE4_VEC_INDEX] = lanePowerOffCtl[0];
		lanePowerDown[LANE5_VEC_INDEX] = lanePowerOffCtl[1];
	end

	// Fallback marks and count of lanes still carrying data
	assign laneFallback = lanePowerOffCtl;

	always_comb begin
		activeLaneCount = '0;
		for (int s = 0; s < SLOT_COUNT; s++) begin
			if (!lanePowerOffCtl[s]) begin
				activeLaneCount = activeLaneCount + SLOT_W'(1);
			end
		end
	end

endmodule : lane_control_regs

// Control fields and receive stage of one lane
module lane_slot
	import lane_control_pkg::*;
#(
	parameter int RX_DATA_W = 32
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  clkEn,
	input  wire logic                  takeWrite,
	input  wire logic [DATA_W-1:0]     wrData,
	input  wire logic [RX_DATA_W-1:0]  rxDataIn,
	input  wire logic                  rxValidIn,
	output logic                       reserveBit,
	output logic                       powerOffCtl,
	output logic                       invertCtl,
	output logic      [RX_DATA_W-1:0]  rxDataOut,
	output logic                       rxValidOut
);

	// Next values of the stored fields
	logic                  next_reserveBit;
	logic                  next_powerOffCtl;
	logic                  next_invertCtl;

	// Next values of the receive stage
	logic [RX_DATA_W-1:0]  next_rxDataOut;
	logic                  next_rxValidOut;

	// Only the three low bits are ever looked at
	always_comb begin
		next_reserveBit = reserveBit;
		if (takeWrite) begin
			next_reserveBit = wrData[RESERVE_BIT];
		end
	end

	always_comb begin
		next_powerOffCtl = powerOffCtl;
		if (takeWrite) begin
			next_powerOffCtl = wrData[POWER_OFF_BIT];
		end
	end

	always_comb begin
		next_invertCtl = invertCtl;
		if (takeWrite) begin
			next_invertCtl = wrData[INVERT_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reserveBit <= RESERVE_RESET;
		end else if (clkEn) begin
			reserveBit <= next_reserveBit;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			powerOffCtl <= POWER_OFF_RESET;
		end else if (clkEn) begin
			powerOffCtl <= next_powerOffCtl;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			invertCtl <= INVERT_RESET;
		end else if (clkEn) begin
			invertCtl <= next_invertCtl;
		end
	end

	// Zeroed data keeps a fallen-back lane from leaking stale words
	always_comb begin
		next_rxDataOut = rxDataIn ^ {RX_DATA_W{invertCtl}};
		if (powerOffCtl) begin
			next_rxDataOut = '0;
		end
	end

	always_comb begin
		next_rxValidOut = rxValidIn && !powerOffCtl;
	end

	// Inversion applies from the cycle after the write; one register stage of latency
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxDataOut <= '0;
		end else if (clkEn) begin
			rxDataOut <= next_rxDataOut;
		end
	end

	// A fallen-back lane carries no valid data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxValidOut <= 1'b0;
		end else if (clkEn) begin
			rxValidOut <= next_rxValidOut;
		end
	end

endmodule : lane_slot

// [tb/lane_control_regs_checker.sv]
// Assertions on the lane control register bank ports
`timescale 1ns/100ps
module lane_control_regs_checker
	import lane_control_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire logic                   clkEn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [ADDR_W-1:0]      paddr,
	input wire logic [DATA_W-1:0]      pwdata,
	input wire logic [STRB_W-1:0]      pstrb,
	input wire logic [DATA_W-1:0]      prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [POWER_VEC_W-1:0] lanePowerDown,
	input wire logic [31:0]            rxDataOut4,
	input wire logic                   rxValidOut4,
	input wire logic [SLOT_COUNT-1:0]  laneFallback,
	input wire logic [SLOT_W-1:0]      activeLaneCount
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic acc;
	assign acc = psel && penable && pready;
	AST_PWR4: assert property (acc && pwrite && paddr == LANE4_CONTROL_OFFSET && pstrb[0]
		|=> lanePowerDown[4] == $past(pwdata[1])) else $error("lane 4 power bit wrong");
	AST_PWR5: assert property (acc && pwrite && paddr == LANE5_CONTROL_OFFSET && pstrb[0]
		|=> lanePowerDown[5] == $past(pwdata[1])) else $error("lane 5 power bit wrong");
	AST_VEC: assert property ({lanePowerDown[7:6], lanePowerDown[3:0]} == 6'h00)
		else $error("foreign power bits set");
	AST_ERR: assert property (psel && !penable && clkEn && !(paddr inside {8'h14, 8'h18}) |=> pslverr)
		else $error("unmapped address accepted");
	AST_RSV: assert property (acc && !pwrite |-> prdata[31:3] == 29'h0000_0000)
		else $error("upper bits not zero");
	AST_FB: assert property (laneFallback == lanePowerDown[5:4]) else $error("fallback mismatch");
	AST_CNT: assert property (activeLaneCount == 2'h2 - laneFallback[0] - laneFallback[1])
		else $error("lane count wrong");
	AST_OFF: assert property (lanePowerDown[4] && clkEn |=> !rxValidOut4 && rxDataOut4 == 32'h0000_0000)
		else $error("powered lane passes data");
	cover property (acc && pwrite);
	cover property (acc && pslverr);
	cover property (rxValidOut4);
	cover property (laneFallback == 2'h3);
endmodule : lane_control_regs_checker
bind lane_control_regs lane_control_regs_checker chk (.*);

// [tb/lane_control_regs_tb_top.sv]
// Bench for the lane control register bank
`timescale 1ns/100ps
module lane_control_regs_tb_top;
	import lane_control_pkg::*;
	logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rxValid4 = 0;
	logic        clkEn = 1, rxValid5 = 0, rxValidOut5;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, rxData4 = 0, prdata, rxDataOut4, r;
	logic [31:0] rxData5 = 0, rxDataOut5;
	logic [3:0]  pstrb = 4'hF;
	logic [7:0]  lanePowerDown;
	logic [1:0]  laneFallback, activeLaneCount;
	logic        pready, pslverr, rxValidOut4, e;
	int          num_errors = 0, checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	lane_control_regs DUT (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lanePowerDown(lanePowerDown), .rxData4(rxData4), .rxValid4(rxValid4),
		.rxDataOut4(rxDataOut4), .rxValidOut4(rxValidOut4), .rxData5(rxData5), .rxValid5(rxValid5),
		.rxDataOut5(rxDataOut5), .rxValidOut5(rxValidOut5), .laneFallback(laneFallback),
		.activeLaneCount(activeLaneCount));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_sys) penable <= 1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			report_and_stop();
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
		xfer(0, a, 0);
		chk("prdata", r, x);
		chk("pslverr", e, ex);
	endtask : rd
	task automatic rx(input logic [31:0] d, input logic [31:0] x, input logic v);
		@(posedge clk_sys) {rxData4, rxValid4} <= {d, 1'b1};
		@(negedge clk_sys);
		@(negedge clk_sys);
		chk("rxDataOut4", rxDataOut4, x);
		chk("rxValidOut4", rxValidOut4, v);
	endtask : rx
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		rd(8'h14, 32'h0000_0004, 0);
		rd(8'h18, 32'h0000_0004, 0);
		rx(32'hA5A5_0F0F, 32'hA5A5_0F0F, 1);
		$display("reset test done");
		xfer(1, 8'h14, 32'hFFFF_FFFF);
		rd(8'h14, 32'h0000_0007, 0);
		chk("lanePowerDown", lanePowerDown, 32'h0000_0010);
		rx(32'h1234_5678, 32'h0000_0000, 0);
		xfer(1, 8'h14, 32'h0000_0001);
		rx(32'h1234_5678, 32'hEDCB_A987, 1);
		xfer(1, 8'h18, 32'h0000_0003);
		rd(8'h18, 32'h0000_0003, 0);
		chk("lanePowerDown", lanePowerDown, 32'h0000_0020);
		chk("activeLaneCount", activeLaneCount, 32'h0000_0001);
		chk("laneFallback", laneFallback, 32'h0000_0002);
		$display("field test done");
		rd(8'h1C, 32'h0000_0000, 1);
		pstrb <= 4'h0;
		xfer(1, 8'h18, 32'h0000_0000);
		pstrb <= 4'hF;
		rd(8'h18, 32'h0000_0003, 0);
		$display("refusal test done");
		@(posedge clk_sys) {clkEn, rxData4} <= {1'b0, 32'hFFFF_0000};
		repeat (2) @(negedge clk_sys);
		chk("rxDataOut4", rxDataOut4, 32'hEDCB_A987);
		@(posedge clk_sys) clkEn <= 1'b1;
		$display("enable test done");
		@(posedge clk_sys) rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h14, 32'h0000_0004, 0);
		rd(8'h18, 32'h0000_0004, 0);
		xfer(1, 8'h18, 32'h0000_0001);
		@(posedge clk_sys) {rxData5, rxValid5} <= {32'h0F0F_00FF, 1'b1};
		repeat (2) @(negedge clk_sys);
		chk("rxDataOut5", rxDataOut5, 32'hF0F0_FF00);
		chk("rxValidOut5", rxValidOut5, 32'h0000_0001);
		$display("second reset test done");
		report_and_stop();
	end
endmodule : lane_control_regs_tb_top
